// >>> src/iox_cfg.svh
// Constants of the eight-bit I/O expander: command codes, reset values,
// status register offsets and fields, and the filter and bus timing counts.
// Assumes it is included by its bare name; the guard allows repeated inclusion.
`ifndef IOX_CFG_SVH
`define IOX_CFG_SVH

// ----------------------------------------------------------------------------
// Serial command bytes and register reset values
// ----------------------------------------------------------------------------
`define IOX_CMD_INPUT    8'h00
`define IOX_CMD_OUTPUT   8'h01
`define IOX_CMD_POLARITY 8'h02
`define IOX_CMD_CONFIG   8'h03
`define IOX_OUTPUT_RST   8'hFF
`define IOX_POLARITY_RST 8'h00
`define IOX_CONFIG_RST   8'hFF
`define IOX_ADDR_HI      4'h4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IOX_PCLK_MHZ     250
`define IOX_SPIKE_NS     50
`define IOX_SPIKE_CYC    (((`IOX_SPIKE_NS * `IOX_PCLK_MHZ) + 999) / 1000)
`define IOX_SCL_MAX_KHZ  400
`define IOX_SCL_HALF_NS  (1000000 / (2 * `IOX_SCL_MAX_KHZ))
`define IOX_SCL_HALF_CYC ((`IOX_SCL_HALF_NS * `IOX_PCLK_MHZ) / 1000)

// ----------------------------------------------------------------------------
// Status registers on the APB side
// ----------------------------------------------------------------------------
`define CSR_CTRL         12'h000
`define CSR_STATUS       12'h004
`define CSR_MASK         12'h008
`define CSR_STATE        12'h00C
`define CTRL_SOFT_POR    0
`define EV_PIN_CHANGE    0
`define EV_REG_WRITE     1
`define EV_WIDTH         2

`endif

// >>> src/iox_pkg.sv
// Types shared by the I/O expander modules.
// Assumes nothing of its surroundings.
`default_nettype none

package iox_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} i2c_state_t;
   typedef enum logic [1:0] {RX_ADDR, RX_CMD, RX_DATA} rx_kind_t;

   typedef struct packed {
      logic [7:0] out_val;
      logic [7:0] pol;
      logic [7:0] dir;
   } port_regs_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;
endpackage

`default_nettype wire

// >>> src/noise_filter.sv
// Spike filter for one serial bus line.
// Assumes the raw line is already synchronous to pclk.
`include "iox_cfg.svh"
`default_nettype none

module noise_filter
   import iox_pkg::*;
#(
   parameter int unsigned SPIKE_CYC = `IOX_SPIKE_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic raw_in,
   output var  logic clean_q
);
   localparam int unsigned CW = $clog2(SPIKE_CYC + 1);

   logic [CW-1:0] cnt_q;

   if (SPIKE_CYC < 1) begin : g_bad_spike
      $error("noise_filter needs a spike length of at least one cycle");
   end

   // ------------------------------------------------------------------------
   // Filter
   // ------------------------------------------------------------------------
   // A level must persist for the full length before the output follows it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q   <= '0;
         clean_q <= 1'b1;
      end else if (raw_in == clean_q) begin
         cnt_q <= '0;
      end else if (cnt_q == CW'(SPIKE_CYC - 1)) begin
         clean_q <= raw_in;
         cnt_q   <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   chk_spike_reject: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(clean_q) |-> $past(cnt_q) == CW'(SPIKE_CYC - 1) && $past(raw_in) == clean_q)
      else $error("Filter output moved before the spike length elapsed.");

endmodule // noise_filter

`default_nettype wire

// >>> src/apb_csr.sv
// APB slave holding control, sticky event status, mask and a state view.
// Assumes a zero-wait APB master on pclk; events are one-cycle pulses.
`include "iox_cfg.svh"
`default_nettype none

module apb_csr
   import iox_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire apb_req_t             req,
   input  wire logic [`EV_WIDTH-1:0] events,
   input  wire logic [31:0]          state_word,
   output apb_rsp_t                  rsp,
   output var  logic                 soft_por_q,
   output logic                      irq
);
   logic [`EV_WIDTH-1:0] status_q;
   logic [`EV_WIDTH-1:0] mask_q;
   logic [`EV_WIDTH-1:0] clr;
   logic [31:0]          prdata_q;
   logic                 pslverr_q;
   logic                 setup;
   logic                 wr;

   function automatic logic mapped(input logic [11:0] a);
      return a == `CSR_CTRL || a == `CSR_STATUS || a == `CSR_MASK || a == `CSR_STATE;
   endfunction

   assign setup = req.psel && !req.penable;
   assign wr    = req.psel && req.penable && req.pwrite && mapped(req.paddr);
   assign clr   = (wr && req.paddr == `CSR_STATUS) ? req.pwdata[`EV_WIDTH-1:0] : '0;

   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   // A new event wins over a clear written in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clr) | events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= '0;
      end else if (wr && req.paddr == `CSR_MASK) begin
         mask_q <= req.pwdata[`EV_WIDTH-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_por_q <= 1'b0;
      end else begin
         soft_por_q <= wr && req.paddr == `CSR_CTRL && req.pwdata[`CTRL_SOFT_POR];
      end
   end

   // Read data is fetched in the setup cycle so the access phase needs no wait.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         pslverr_q <= !mapped(req.paddr);
         case (req.paddr)
            `CSR_STATUS: prdata_q <= {{(32-`EV_WIDTH){1'b0}}, status_q};
            `CSR_MASK:   prdata_q <= {{(32-`EV_WIDTH){1'b0}}, mask_q};
            `CSR_STATE:  prdata_q <= state_word;
            default:     prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign rsp = '{prdata: prdata_q, pready: 1'b1, pslverr: pslverr_q};
   assign irq = |(status_q & mask_q);

endmodule // apb_csr

`default_nettype wire

// >>> src/i2c_io_expander.sv
// Eight-bit I/O expander behind a serial two-wire target, with an APB view.
// Assumes scl_in, sda_in and port_in are synchronous to pclk; bit 0 of the
// port is port_pin_zero and bit 7 is port_pin_seven.
//
// Summary of operation
// - After reset every port pin is an input and drives nothing.
// - Direction bits written by the master make each pin input or output.
// - Input register samples pins; output register holds driven values until rewritten.
// - Polarity bits invert the reported input register bits pin by pin.
// - Every register returns its current contents on a master read.
// - Power-on reset restores register defaults and idles the bus machine.
// - Interrupt asserts while any input pin differs from the captured input value.
// - Interrupt output is open drain, pulled low while active.
// - Three strap inputs complete the bus address match, eight devices per bus.
// - Serial interface works up to fast mode; master stays within it.
// - Short spikes on clock and data are filtered before the bus machine.
`include "iox_cfg.svh"
`default_nettype none

module i2c_io_expander
   import iox_pkg::*;
#(
   parameter int unsigned SPIKE_CYC = `IOX_SPIKE_CYC,
   parameter logic [3:0]  ADDR_HI   = `IOX_ADDR_HI
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic [2:0]  addr_strap,
   input  wire logic [7:0]  port_in,
   output logic      [7:0]  port_out,
   output logic      [7:0]  port_oe_n,
   output logic             int_out,
   output logic             int_oe_n
);
   i2c_state_t   st_q;
   rx_kind_t     kind_q;
   port_regs_t   regs_q;
   apb_rsp_t     rsp;
   apb_req_t     apb_req;
   logic [3:0]   cnt_q;
   logic [7:0]   shreg_q;
   logic [7:0]   tx_sh_q;
   logic [7:0]   cmd_q;
   logic [7:0]   in_q;
   logic [7:0]   snap_q;
   logic [7:0]   rd_byte;
   logic [7:0]   diff;
   logic         rw_q;
   logic         drive_q;
   logic         nack_q;
   logic         snap_ok_q;
   logic         int_act_q;
   logic         scl_f;
   logic         sda_f;
   logic         scl_p_q;
   logic         sda_p_q;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_c;
   logic         stop_c;
   logic         addr_hit;
   logic         wr_stb;
   logic         ld_stb;
   logic         soft_por;

   // Spikes must stay well inside an SCL half period at the fastest rate.
   if (SPIKE_CYC < 1 || SPIKE_CYC >= `IOX_SCL_HALF_CYC / 4) begin : g_bad_rate
      $error("i2c_io_expander spike length cannot serve a fast mode bus");
   end

   function automatic logic [7:0] read_reg(input logic [7:0] cmd, input port_regs_t r,
                                           input logic [7:0] pins);
      case (cmd)
         `IOX_CMD_INPUT:    return pins ^ r.pol;
         `IOX_CMD_OUTPUT:   return r.out_val;
         `IOX_CMD_POLARITY: return r.pol;
         `IOX_CMD_CONFIG:   return r.dir;
         default:           return 8'h00;
      endcase
   endfunction

   // ------------------------------------------------------------------------
   // Line conditioning and bus conditions
   // ------------------------------------------------------------------------
   noise_filter #(.SPIKE_CYC(SPIKE_CYC)) u_scl_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .raw_in  (scl_in),
      .clean_q (scl_f)
   );

   noise_filter #(.SPIKE_CYC(SPIKE_CYC)) u_sda_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .raw_in  (sda_in),
      .clean_q (sda_f)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
      end
   end

   assign scl_rise = scl_f && !scl_p_q;
   assign scl_fall = !scl_f && scl_p_q;
   assign start_c  = scl_f && scl_p_q && sda_p_q && !sda_f;
   assign stop_c   = scl_f && scl_p_q && !sda_p_q && sda_f;
   assign addr_hit = shreg_q[7:1] == {ADDR_HI, addr_strap};
   assign rd_byte  = read_reg(cmd_q, regs_q, in_q);
   assign wr_stb   = st_q == ST_RX && kind_q == RX_DATA && scl_fall && cnt_q == 4'd8 && !soft_por;
   assign ld_stb   = scl_fall && !soft_por &&
                     ((st_q == ST_ACK && kind_q == RX_ADDR && rw_q) || (st_q == ST_RACK && !nack_q));

   // ------------------------------------------------------------------------
   // Bus state machine
   // ------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= ST_IDLE;
         kind_q  <= RX_ADDR;
         cnt_q   <= 4'h0;
         rw_q    <= 1'b0;
         shreg_q <= 8'h00;
         tx_sh_q <= 8'h00;
         drive_q <= 1'b0;
         nack_q  <= 1'b0;
      end else if (soft_por || stop_c) begin
         st_q    <= ST_IDLE;
         drive_q <= 1'b0;
      end else if (start_c) begin
         st_q    <= ST_RX;
         kind_q  <= RX_ADDR;
         cnt_q   <= 4'h0;
         drive_q <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               drive_q <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise && cnt_q != 4'd8) begin
                  shreg_q <= {shreg_q[6:0], sda_f};
                  cnt_q   <= cnt_q + 4'd1;
               end else if (scl_fall && cnt_q == 4'd8) begin
                  if (kind_q == RX_ADDR && !addr_hit) begin
                     st_q <= ST_IDLE;
                  end else begin
                     st_q    <= ST_ACK;
                     drive_q <= 1'b1;
                     if (kind_q == RX_ADDR) begin
                        rw_q <= shreg_q[0];
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall && kind_q == RX_ADDR && rw_q) begin
                  st_q    <= ST_TX;
                  tx_sh_q <= rd_byte;
                  drive_q <= ~rd_byte[7];
                  cnt_q   <= 4'h0;
               end else if (scl_fall) begin
                  st_q    <= ST_RX;
                  drive_q <= 1'b0;
                  cnt_q   <= 4'h0;
                  kind_q  <= (kind_q == RX_ADDR) ? RX_CMD : RX_DATA;
               end
            end
            ST_TX: begin
               if (scl_fall && cnt_q == 4'd7) begin
                  st_q    <= ST_RACK;
                  drive_q <= 1'b0;
               end else if (scl_fall) begin
                  tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                  drive_q <= ~tx_sh_q[6];
                  cnt_q   <= cnt_q + 4'd1;
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_q <= sda_f;
               end else if (scl_fall && nack_q) begin
                  st_q <= ST_IDLE;
               end else if (scl_fall) begin
                  st_q    <= ST_TX;
                  tx_sh_q <= rd_byte;
                  drive_q <= ~rd_byte[7];
                  cnt_q   <= 4'h0;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_q <= `IOX_CMD_INPUT;
      end else if (soft_por) begin
         cmd_q <= `IOX_CMD_INPUT;
      end else if (st_q == ST_RX && kind_q == RX_CMD && scl_fall && cnt_q == 4'd8) begin
         cmd_q <= shreg_q;
      end
   end

   // ------------------------------------------------------------------------
   // Port registers
   // ------------------------------------------------------------------------
   // Repeated data bytes rewrite the same register; the pointer never moves.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regs_q <= '{out_val: `IOX_OUTPUT_RST, pol: `IOX_POLARITY_RST, dir: `IOX_CONFIG_RST};
      end else if (soft_por) begin
         regs_q <= '{out_val: `IOX_OUTPUT_RST, pol: `IOX_POLARITY_RST, dir: `IOX_CONFIG_RST};
      end else if (wr_stb) begin
         case (cmd_q)
            `IOX_CMD_OUTPUT:   regs_q.out_val <= shreg_q;
            `IOX_CMD_POLARITY: regs_q.pol     <= shreg_q;
            `IOX_CMD_CONFIG:   regs_q.dir     <= shreg_q;
            default:           regs_q         <= regs_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_q <= 8'h00;
      end else begin
         in_q <= port_in;
      end
   end

   assign port_out  = regs_q.out_val;
   assign port_oe_n = regs_q.dir;
   assign sda_out   = 1'b0;
   assign sda_oe_n  = ~drive_q;

   // ------------------------------------------------------------------------
   // Change interrupt
   // ------------------------------------------------------------------------
   // The reference is primed from the pins after reset, so an idle port raises nothing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_q    <= 8'h00;
         snap_ok_q <= 1'b0;
      end else if (soft_por) begin
         snap_ok_q <= 1'b0;
      end else if (!snap_ok_q) begin
         snap_q    <= port_in;
         snap_ok_q <= 1'b1;
      end else if (ld_stb && cmd_q == `IOX_CMD_INPUT) begin
         snap_q <= in_q;
      end
   end

   assign diff = (in_q ^ snap_q) & regs_q.dir;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_act_q <= 1'b0;
      end else begin
         int_act_q <= snap_ok_q && !soft_por && |diff;
      end
   end

   assign int_out  = 1'b0;
   assign int_oe_n = ~int_act_q;

   // ------------------------------------------------------------------------
   // APB status view
   // ------------------------------------------------------------------------
   assign apb_req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

   apb_csr u_csr (
      .pclk       (pclk),
      .presetn    (presetn),
      .req        (apb_req),
      .events     ({wr_stb, snap_ok_q && !soft_por && |diff && !int_act_q}),
      .state_word ({5'h00, addr_strap, regs_q.dir, regs_q.out_val, in_q}),
      .rsp        (rsp),
      .soft_por_q (soft_por),
      .irq        (irq)
   );

   assign prdata  = rsp.prdata;
   assign pready  = rsp.pready;
   assign pslverr = rsp.pslverr;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_addr_done;
      st_q == ST_RX && kind_q == RX_ADDR && scl_fall && cnt_q == 4'd8 && !soft_por;
   endsequence

   chk_por_inputs: assert property (soft_por |=> port_oe_n == 8'hFF && regs_q.pol == 8'h00)
      else $error("Reset left a pin driven or polarity set.");
   chk_dir_write: assert property (wr_stb && cmd_q == `IOX_CMD_CONFIG |=> port_oe_n == $past(shreg_q))
      else $error("Direction write did not reach the pins.");
   chk_out_hold: assert property (!(wr_stb && cmd_q == `IOX_CMD_OUTPUT) && !soft_por |=> $stable(port_out))
      else $error("Output value changed without a write.");
   chk_pol_read: assert property (ld_stb && cmd_q == `IOX_CMD_INPUT |=> tx_sh_q == $past(in_q ^ regs_q.pol))
      else $error("Input read did not apply polarity.");
   chk_cfg_read: assert property (ld_stb && cmd_q == `IOX_CMD_CONFIG |=> tx_sh_q == $past(regs_q.dir) && sda_oe_n == $past(regs_q.dir[7]))
      else $error("Direction read back wrong.");
   chk_por_idle: assert property (soft_por |=> st_q == ST_IDLE && sda_oe_n ##1 !int_act_q)
      else $error("Reset did not idle the bus machine.");
   chk_int_assert: assert property (snap_ok_q && |diff && !soft_por |=> !int_oe_n && !int_out)
      else $error("Input change did not pull the interrupt low.");
   chk_int_release: assert property (diff == 8'h00 |=> int_oe_n)
      else $error("Interrupt stayed low with no difference.");
   chk_read_recapture: assert property (ld_stb && cmd_q == `IOX_CMD_INPUT && snap_ok_q |=> snap_q == $past(in_q))
      else $error("Input read did not recapture the reference.");
   chk_addr_reject: assert property (s_addr_done and !addr_hit |=> st_q == ST_IDLE && sda_oe_n)
      else $error("Foreign address was acknowledged.");
   chk_addr_accept: assert property (s_addr_done and addr_hit |=> !sda_oe_n && st_q == ST_ACK)
      else $error("Own address was not acknowledged.");

endmodule // i2c_io_expander

`default_nettype wire

// >>> test/i2c_master_model.sv
// Two-wire bus master model that drives the clock and pulls the data line.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`default_nettype none

module i2c_master_model #(
   parameter int Q = 157
) (
   input  wire logic pclk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_low
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // Four quarters of Q cycles per bit keep the clock just under fast mode.
   task automatic bit_io(input logic drv_low, output logic got);
      sda_low <= drv_low;
      repeat (Q) @(posedge pclk);
      scl <= 1'b1;
      repeat (Q) @(posedge pclk);
      got = sda;
      repeat (Q) @(posedge pclk);
      scl <= 1'b0;
      repeat (Q) @(posedge pclk);
   endtask

   task automatic start();
      sda_low <= 1'b0;
      repeat (Q) @(posedge pclk);
      scl <= 1'b1;
      repeat (Q) @(posedge pclk);
      sda_low <= 1'b1;
      repeat (Q) @(posedge pclk);
      scl <= 1'b0;
      repeat (Q) @(posedge pclk);
   endtask

   task automatic stop();
      sda_low <= 1'b1;
      repeat (Q) @(posedge pclk);
      scl <= 1'b1;
      repeat (Q) @(posedge pclk);
      sda_low <= 1'b0;
      repeat (Q) @(posedge pclk);
   endtask

   // A read byte is always refused with a released ninth bit, ending the read.
   task automatic xfer(input logic [7:0] wd, input logic rd, output logic [7:0] rv,
                       output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(!rd && !wd[i], g);
         rv[i] = g;
      end
      bit_io(1'b0, g);
      ack = !g;
   endtask
endmodule // i2c_master_model

`default_nettype wire

// >>> test/tb_i2c_io_expander.sv
// Self-checking bench for the I/O expander: APB tasks, bus scenarios, verdict.
// Assumes the master model is compiled first and the header is on the path.
`include "iox_cfg.svh"
`default_nettype none

module tb_i2c_io_expander;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] DEV_A = {`IOX_ADDR_HI, 3'b101};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        sda_out, sda_oe_n, int_out, int_oe_n, scl, sda_low, sda;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  port_in, port_out, port_oe_n;
   int          n_mismatch, n_checks, cyc;

   assign sda = sda_low ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);

   i2c_io_expander #(.SPIKE_CYC(2)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap(3'b101), .port_in(port_in),
      .port_out(port_out), .port_oe_n(port_oe_n), .int_out(int_out), .int_oe_n(int_oe_n));

   i2c_master_model #(.Q(157)) m (.pclk(pclk), .sda(sda), .scl(scl), .sda_low(sda_low));

   // ------------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic bus_wr(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      logic a;
      m.start();
      m.xfer({DEV_A, 1'b0}, 1'b0, x, a);
      chk("addr_ack", 32'h1, {31'h0, a});
      m.xfer(c, 1'b0, x, a);
      m.xfer(d, 1'b0, x, a);
      chk("data_ack", 32'h1, {31'h0, a});
      m.stop();
   endtask

   task automatic t_reset();
      logic [31:0] r;
      logic e;
      chk("port_oe_n", 32'hFF, {24'h0, port_oe_n});
      chk("int_oe_n", 32'h1, {31'h0, int_oe_n});
      apb(1'b0, `CSR_STATE, 32'h0, r, e);
      chk("state", 32'h05FF_FF3C, r);
      apb(1'b0, 12'h010, 32'h0, r, e);
      chk("slverr", 32'h1, {31'h0, e});
      $display("t_reset done");
   endtask

   task automatic t_write();
      logic [31:0] r;
      logic [7:0] x;
      logic e;
      apb(1'b1, `CSR_MASK, 32'h3, r, e);
      bus_wr(`IOX_CMD_POLARITY, 8'h81);
      bus_wr(`IOX_CMD_OUTPUT, 8'hA5);
      bus_wr(`IOX_CMD_CONFIG, 8'h0F);
      chk("port_oe_n", 32'h0F, {24'h0, port_oe_n});
      chk("port_out", 32'hA5, {24'h0, port_out});
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, `CSR_STATUS, 32'h0, r, e);
      chk("status", 32'h2, r);
      apb(1'b1, `CSR_STATUS, 32'h2, r, e);
      apb(1'b0, `CSR_STATUS, 32'h0, r, e);
      chk("status_clr", 32'h0, r);
      chk("irq_clr", 32'h0, {31'h0, irq});
      m.start();
      m.xfer({`IOX_ADDR_HI, 3'b010, 1'b0}, 1'b0, x, e);
      chk("foreign_ack", 32'h0, {31'h0, e});
      // The pointer still names the direction register from the last write.
      m.start();
      m.xfer({DEV_A, 1'b1}, 1'b0, x, e);
      m.xfer(8'hFF, 1'b1, x, e);
      chk("cfg_read", 32'h0F, {24'h0, x});
      m.stop();
      $display("t_write done");
   endtask

   task automatic t_irq();
      logic [7:0]  x, v;
      logic [31:0] r;
      logic        a, e;
      port_in <= 8'h3D;
      repeat (4) @(posedge pclk);
      chk("int_low", 32'h0, {31'h0, int_oe_n});
      port_in <= 8'h3C;
      repeat (4) @(posedge pclk);
      chk("int_back", 32'h1, {31'h0, int_oe_n});
      apb(1'b1, `CSR_STATUS, 32'h1, r, e);
      port_in <= 8'hBD;
      repeat (4) @(posedge pclk);
      chk("irq_pin", 32'h1, {31'h0, irq});
      m.start();
      m.xfer({DEV_A, 1'b0}, 1'b0, x, a);
      m.xfer(`IOX_CMD_INPUT, 1'b0, x, a);
      m.start();
      m.xfer({DEV_A, 1'b1}, 1'b0, x, a);
      m.xfer(8'hFF, 1'b1, v, a);
      m.stop();
      chk("input", 32'h3C, {24'h0, v});
      chk("int_read", 32'h1, {31'h0, int_oe_n});
      $display("t_irq done");
   endtask

   task automatic t_soft();
      logic [31:0] r;
      logic e;
      apb(1'b1, `CSR_CTRL, 32'h1, r, e);
      repeat (3) @(posedge pclk);
      chk("out_rst", 32'hFF, {24'h0, port_out});
      chk("dir_rst", 32'hFF, {24'h0, port_oe_n});
      $display("t_soft done");
   endtask

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // A bit takes 628 cycles and sixteen bytes cross, so the ceiling leaves a small margin.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 99000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      port_in = 8'h3C;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      t_reset();
      t_write();
      t_irq();
      t_soft();
      final_report();
   end
endmodule // tb_i2c_io_expander

`default_nettype wire
